/* hw/nad_consts.vh */
// Field positions, opcode codes and reset values of the nibble arithmetic unit
`ifndef NAD_CONSTS_VH
`define NAD_CONSTS_VH

// Instruction word layout
`define NAD_INSTR_W        16
`define NAD_GRP_HI         15
`define NAD_GRP_LO         14
`define NAD_SUB_BIT        13
`define NAD_IMM_BIT        12
`define NAD_CIN_BIT        11
`define NAD_SKIP_BIT       10
`define NAD_ROW_HI         9
`define NAD_ROW_LO         8
`define NAD_COL_HI         7
`define NAD_COL_LO         4
`define NAD_OPD_HI         3
`define NAD_OPD_LO         0

// Group code in bits f..e shared by all sixteen arithmetic opcodes
`define NAD_GRP_ARITH      2'h1

// Full six-bit opcode codes, bits f..a
`define NAD_OP_PLUS_M2R            6'h10
`define NAD_OP_PLUS_M2R_CY_SKIP    6'h11
`define NAD_OP_PLUS_M2R_CIN        6'h12
`define NAD_OP_PLUS_M2R_CIN_SKIP   6'h13
`define NAD_OP_PLUS_I2M            6'h14
`define NAD_OP_PLUS_I2M_CY_SKIP    6'h15
`define NAD_OP_PLUS_I2M_CIN        6'h16
`define NAD_OP_PLUS_I2M_CIN_SKIP   6'h17
`define NAD_OP_MINUS_MFR           6'h18
`define NAD_OP_MINUS_IFM_BWIN_SKIP 6'h1F

// Address and nibble widths and the first memory page
`define NAD_ROW_W          2
`define NAD_COL_W          4
`define NAD_ADDR_W         6
`define NAD_NIB_W          4
`define NAD_FIRST_PAGE     2'h0

// Reset values
`define NAD_CARRY_RST      1'h0
`define NAD_SKIP_RST       1'h0
`define NAD_NIB_RST        4'h0
`define NAD_ADDR_RST       6'h00
`define NAD_INSTR_RST      16'h0000

`endif

/* hw/nad_nibble_alu.v */
// Four-bit adder and subtractor with optional carry or borrow input
`default_nettype none

module nad_nibble_alu (
   input  wire [3:0] a_in,
   input  wire [3:0] b_in,
   input  wire       sub_in,
   input  wire       ci_in,
   output wire [3:0] result_out,
   output wire       co_out
);

   wire [4:0] sum5;
   wire [4:0] diff5;

   assign sum5  = {1'h0, a_in} + {1'h0, b_in} + {4'h0, ci_in};
   // Bit 4 of the wrapped difference is the borrow out of the nibble
   assign diff5 = {1'h0, a_in} - {1'h0, b_in} - {4'h0, ci_in};

   assign result_out = sub_in ? diff5[3:0] : sum5[3:0];
   assign co_out     = sub_in ? diff5[4]   : sum5[4];

endmodule // nad_nibble_alu

`default_nettype wire

/* hw/nad_arith_decoder.v */
// Decoder and sequencer for the nibble add and subtract instruction groups
`default_nettype none
`include "nad_consts.vh"

// What this block does
// RULE1 - Row field from instruction bits nine, eight
// RULE2 - Column field from instruction bits seven to four
// RULE3 - Memory operand address is row then column
// RULE4 - Register forms: low bits pick page-zero register
// RULE5 - Immediate forms: low bits are immediate nibble
// RULE6 - Register plus memory into register, optional skip
// RULE7 - Same with carry flag added in
// RULE8 - Memory plus immediate back into memory
// RULE9 - Memory plus immediate plus carry into memory
// RULE10 - Register minus memory, optionally minus borrow
// RULE11 - Memory minus immediate, optionally minus borrow
// RULE12 - Odd subtract opcodes skip on borrow
// RULE13 - Skipped instruction is fetched but has no effect
// RULE14 - Carry flag follows every add and subtract
module nad_arith_decoder (
   input  wire                  clk_in,
   input  wire                  reset_in,
   input  wire [15:0]           instr_in,
   input  wire                  instr_valid_in,
   input  wire [3:0]            mem_rdata_in,
   output reg                   instr_ready_out,
   output reg  [5:0]            mem_addr_out,
   output reg                   mem_rd_out,
   output reg                   mem_wr_out,
   output reg  [3:0]            mem_wdata_out,
   output reg                   carry_flag_out,
   output reg                   skip_pending_out,
   output reg                   done_out,
   output reg                   discarded_out,
   output reg                   not_arith_out
);

   localparam [1:0] S_IDLE  = 2'h0;
   localparam [1:0] S_RDREG = 2'h1;
   localparam [1:0] S_RDMEM = 2'h2;
   localparam [1:0] S_EXEC  = 2'h3;

   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [15:0] instr_reg;
   reg  [15:0] instr_next;
   reg  [3:0]  opa_reg;
   reg  [3:0]  opa_next;
   reg  [5:0]  addr_next;
   reg         rd_next;
   reg         wr_next;
   reg  [3:0]  wdata_next;
   reg         carry_next;
   reg         skip_next;
   reg         ready_next;
   reg         done_next;
   reg         discard_next;
   reg         not_arith_next;

   // Fields of the incoming word, used when the word is taken
   wire [1:0]  in_row;
   wire [3:0]  in_col;
   wire [3:0]  in_opd;
   wire        in_arith;
   wire        in_imm;

   // Fields of the held word, used while it executes
   wire [1:0]  row_addr_field;
   wire [3:0]  column_addr_field;
   wire [3:0]  low_opd;
   wire [5:0]  mem_operand_addr;
   wire [5:0]  reg_operand_addr;
   wire        is_sub;
   wire        is_imm;
   wire        use_flag_in;
   wire        skip_on_out;

   wire [3:0]  alu_a;
   wire [3:0]  alu_b;
   wire        alu_ci;
   wire [3:0]  alu_result;
   wire        alu_co;

   assign in_row   = instr_in[`NAD_ROW_HI:`NAD_ROW_LO];      // [RULE1]
   assign in_col   = instr_in[`NAD_COL_HI:`NAD_COL_LO];      // [RULE2]
   assign in_opd   = instr_in[`NAD_OPD_HI:`NAD_OPD_LO];
   assign in_arith = (instr_in[`NAD_GRP_HI:`NAD_GRP_LO] == `NAD_GRP_ARITH);
   assign in_imm   = instr_in[`NAD_IMM_BIT];

   assign row_addr_field    = instr_reg[`NAD_ROW_HI:`NAD_ROW_LO]; // [RULE1]
   assign column_addr_field = instr_reg[`NAD_COL_HI:`NAD_COL_LO]; // [RULE2]
   assign low_opd           = instr_reg[`NAD_OPD_HI:`NAD_OPD_LO];
   assign mem_operand_addr  = {row_addr_field, column_addr_field}; // [RULE3]
   assign reg_operand_addr  = {`NAD_FIRST_PAGE, low_opd};         // [RULE4]
   assign is_sub      = instr_reg[`NAD_SUB_BIT];
   assign is_imm      = instr_reg[`NAD_IMM_BIT];
   assign use_flag_in = instr_reg[`NAD_CIN_BIT];
   assign skip_on_out = instr_reg[`NAD_SKIP_BIT];

   // In register forms the register was read first and held in opa_reg,
   // the memory nibble is on the read port now; in immediate forms the
   // memory nibble is the first operand and the low field the second.
   assign alu_a  = is_imm ? mem_rdata_in : opa_reg;          // [RULE4]
   assign alu_b  = is_imm ? low_opd : mem_rdata_in;          // [RULE5]
   // Carry adds in, borrow subtracts, only for the "with flag" opcodes
   assign alu_ci = use_flag_in & carry_flag_out; // [RULE7] [RULE9]

   nad_nibble_alu u_alu (
      .a_in       (alu_a),
      .b_in       (alu_b),
      .sub_in     (is_sub),                  // [RULE10] [RULE11]
      .ci_in      (alu_ci),
      .result_out (alu_result),
      .co_out     (alu_co)
   );

   always @* begin
      state_next     = state_reg;
      instr_next     = instr_reg;
      opa_next       = opa_reg;
      addr_next      = mem_addr_out;
      rd_next        = 1'h0;
      wr_next        = 1'h0;
      wdata_next     = mem_wdata_out;
      carry_next     = carry_flag_out;
      skip_next      = skip_pending_out;
      ready_next     = 1'h0;
      done_next      = 1'h0;
      discard_next   = 1'h0;
      not_arith_next = 1'h0;
      case (state_reg)
         S_IDLE: begin
            ready_next = 1'h1;
            if (instr_valid_in && instr_ready_out) begin
               if (skip_pending_out) begin
                  // Fetched but dropped: no access, flag untouched
                  skip_next    = 1'h0;                       // [RULE13]
                  discard_next = 1'h1;                       // [RULE13]
                  done_next    = 1'h1;
               end else if (!in_arith) begin
                  // Other groups belong to other units; just hand back
                  not_arith_next = 1'h1;
                  done_next      = 1'h1;
               end else begin
                  instr_next = instr_in;
                  ready_next = 1'h0;
                  rd_next    = 1'h1;
                  if (in_imm) begin
                     addr_next  = {in_row, in_col};          // [RULE3]
                     state_next = S_RDMEM;
                  end else begin
                     addr_next  = {`NAD_FIRST_PAGE, in_opd}; // [RULE4]
                     state_next = S_RDREG;
                  end
               end
            end
         end
         S_RDREG: begin
            // Register read is on the port; ask for the memory nibble next
            addr_next  = mem_operand_addr;                   // [RULE3]
            rd_next    = 1'h1;
            state_next = S_RDMEM;
         end
         S_RDMEM: begin
            // Holds the register value in register forms; a stale value
            // in immediate forms is captured but never used
            opa_next   = mem_rdata_in;
            state_next = S_EXEC;
         end
         S_EXEC: begin
            wr_next    = 1'h1;
            wdata_next = alu_result;                         // [RULE6]
            // Register forms write the register, immediate forms memory
            addr_next  = is_imm ? mem_operand_addr           // [RULE8]
                                : reg_operand_addr;          // [RULE10]
            carry_next = alu_co;                             // [RULE14]
            // Odd opcodes arm a skip on carry or borrow out
            skip_next  = skip_on_out & alu_co;               // [RULE12]
            done_next  = 1'h1;
            ready_next = 1'h1;
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end


   always @(posedge clk_in) begin
      if (reset_in) begin
         state_reg        <= S_IDLE;
         instr_reg        <= `NAD_INSTR_RST;
         opa_reg          <= `NAD_NIB_RST;
         mem_addr_out     <= `NAD_ADDR_RST;
         mem_rd_out       <= 1'h0;
         mem_wr_out       <= 1'h0;
         mem_wdata_out    <= `NAD_NIB_RST;
         carry_flag_out   <= `NAD_CARRY_RST;
         skip_pending_out <= `NAD_SKIP_RST;
         instr_ready_out  <= 1'h0;
         done_out         <= 1'h0;
         discarded_out    <= 1'h0;
         not_arith_out    <= 1'h0;
      end else begin
         state_reg        <= state_next;
         instr_reg        <= instr_next;
         opa_reg          <= opa_next;
         mem_addr_out     <= addr_next;
         mem_rd_out       <= rd_next;
         mem_wr_out       <= wr_next;
         mem_wdata_out    <= wdata_next;
         carry_flag_out   <= carry_next;
         skip_pending_out <= skip_next;
         instr_ready_out  <= ready_next;
         done_out         <= done_next;
         discarded_out    <= discard_next;
         not_arith_out    <= not_arith_next;
      end
   end

endmodule // nad_arith_decoder

`default_nettype wire

/* tb/nad_arith_chk.sv */
// Port-level property checker for the nibble arithmetic decoder
`default_nettype none
module nad_arith_chk (
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic [15:0] instr_in,
   input wire logic        instr_valid_in,
   input wire logic [3:0]  mem_rdata_in,
   input wire logic        instr_ready_out,
   input wire logic [5:0]  mem_addr_out,
   input wire logic        mem_rd_out,
   input wire logic        mem_wr_out,
   input wire logic [3:0]  mem_wdata_out,
   input wire logic        carry_flag_out,
   input wire logic        skip_pending_out,
   input wire logic        done_out,
   input wire logic        discarded_out,
   input wire logic        not_arith_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic       go;
   logic       imm;
   logic       regf;
   logic [5:0] rc;
   logic [3:0] lo;
   assign go = instr_valid_in && instr_ready_out && !skip_pending_out;
   assign imm = go && instr_in[15:14] == 2'h1 && instr_in[12];
   assign regf = go && instr_in[15:14] == 2'h1 && !instr_in[12];
   assign rc = instr_in[9:4];
   assign lo = instr_in[3:0];
   a_imm_addr: assert property (imm |=>
      mem_rd_out && mem_addr_out == $past(rc))
      else $error("immediate operand address wrong");
   a_reg_addr: assert property (regf |=>
      mem_rd_out && mem_addr_out == {2'h0, $past(lo)}
      ##1 mem_rd_out && mem_addr_out == $past(rc, 2))
      else $error("register form reads wrong");
   a_imm_done: assert property (imm |-> ##3
      done_out && mem_wr_out && mem_addr_out == $past(rc, 3))
      else $error("memory write-back wrong");
   a_reg_done: assert property (regf |-> ##4
      done_out && mem_wr_out && mem_addr_out == {2'h0, $past(lo, 4)})
      else $error("register write wrong");
   // Bits d..b are subtract, immediate, flag-in: plain add is 010
   a_imm_add: assert property (imm && instr_in[13:11] == 3'h2
      |-> ##3 mem_wdata_out == $past(mem_rdata_in) + $past(lo, 3))
      else $error("sum wrong");
   a_imm_sub: assert property (imm && instr_in[13:11] == 3'h6
      |-> ##3 mem_wdata_out == $past(mem_rdata_in) - $past(lo, 3))
      else $error("diff wrong");
   a_skip_quiet: assert property (instr_valid_in && instr_ready_out
      && skip_pending_out |=> done_out && discarded_out && !mem_wr_out
      && !mem_rd_out && !skip_pending_out)
      else $error("skipped word had an effect");
   a_flag_moves: assert property ($changed(carry_flag_out)
      |-> done_out && mem_wr_out)
      else $error("flag changed outside an executed word");
   a_skip_rise: assert property ($rose(skip_pending_out)
      |-> mem_wr_out && carry_flag_out)
      else $error("skip armed without carry or borrow");
   cover property (imm);
   cover property (regf);
   cover property (discarded_out);
   cover property (not_arith_out);
endmodule // nad_arith_chk

bind nad_arith_decoder nad_arith_chk u_chk (
   .clk_in           (clk_in),
   .reset_in         (reset_in),
   .instr_in         (instr_in),
   .instr_valid_in   (instr_valid_in),
   .mem_rdata_in     (mem_rdata_in),
   .instr_ready_out  (instr_ready_out),
   .mem_addr_out     (mem_addr_out),
   .mem_rd_out       (mem_rd_out),
   .mem_wr_out       (mem_wr_out),
   .mem_wdata_out    (mem_wdata_out),
   .carry_flag_out   (carry_flag_out),
   .skip_pending_out (skip_pending_out),
   .done_out         (done_out),
   .discarded_out    (discarded_out),
   .not_arith_out    (not_arith_out)
);
`default_nettype wire

/* tb/nad_arith_decoder_tb.sv */
// Self-checking bench for the nibble arithmetic decoder
`default_nettype none
module nad_arith_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [15:0] instr_in = 16'h0000;
   logic        instr_valid_in = 1'b0;
   logic [3:0]  mem_rdata_in = 4'h0;
   logic        rdy, wr, rd, cf_o, skp, done, disc, na;
   logic [5:0]  addr;
   logic [3:0]  wdat;
   logic [3:0]  mem [0:63];
   logic        cf = 1'b0;
   int          num_errors = 0;
   int          n_tests = 0;
   nad_arith_decoder DUT (.clk_in(clk_in), .reset_in(reset_in),
      .instr_in(instr_in), .instr_valid_in(instr_valid_in),
      .mem_rdata_in(mem_rdata_in), .instr_ready_out(rdy), .mem_addr_out(addr),
      .mem_rd_out(rd), .mem_wr_out(wr), .mem_wdata_out(wdat),
      .carry_flag_out(cf_o), .skip_pending_out(skp), .done_out(done),
      .discarded_out(disc), .not_arith_out(na));
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   // Data memory: one-cycle read latency, inverted junk when not read
   always @(posedge clk_in) begin
      if (wr) mem[addr] <= wdat;
      mem_rdata_in <= rd ? mem[addr] : ~mem_rdata_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("errors=%0d checks=%0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Offers one word and returns at the negedge of its done cycle
   task automatic offer(input logic [15:0] w);
      int k;
      @(posedge clk_in);
      instr_in <= w;
      instr_valid_in <= 1'b1;
      // Look at ready only once it has settled, mid-cycle
      @(negedge clk_in);
      for (k = 0; k < 20 && rdy !== 1'b1; k++) @(negedge clk_in);
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      k = 0;
      do begin
         @(negedge clk_in);
         k++;
      end while (done !== 1'b1 && k < 8);
      chk(done, 1'b1);
   endtask
   task automatic exec(input logic [15:0] w);
      logic [5:0] ma;
      logic [3:0] a;
      logic [3:0] b;
      logic [4:0] r;
      // Let the last write-back land in the model before reading it
      @(negedge clk_in);
      ma = w[9:4];
      a = w[12] ? mem[ma] : mem[{2'h0, w[3:0]}];
      b = w[12] ? w[3:0] : mem[ma];
      r = w[13] ? {1'b0, a} - {1'b0, b} - (w[11] & cf)
                : {1'b0, a} + {1'b0, b} + (w[11] & cf);
      offer(w);
      chk(wdat, r[3:0]);
      chk(addr, w[12] ? ma : {2'h0, w[3:0]});
      chk(cf_o, r[4]);
      chk(skp, w[10] & r[4]);
      cf = r[4];
      if (w[10] & r[4]) begin
         offer(w);
         chk(disc, 1'b1);
         chk(wr, 1'b0);
         chk(cf_o, cf);
         chk(skp, 1'b0);
      end
   endtask
   task automatic t_all_ops();
      int i, p;
      for (i = 0; i < 64; i++) mem[i] = 4'(i * 5 + 3);
      for (p = 0; p < 2; p++)
         for (i = 0; i < 16; i++)
            exec({2'h1, 4'(i), 2'(i + p), 4'(i * 3), 4'(i + p * 9)});
   endtask
   task automatic t_edges();
      mem[63] = 4'hF;
      exec({6'h15, 2'h3, 4'hF, 4'hF});
      exec({6'h1F, 2'h0, 4'h0, 4'hF});
      exec({6'h11, 2'h3, 4'hF, 4'hF});
      exec({6'h19, 2'h0, 4'h5, 4'h5});
   endtask
   task automatic t_nonarith();
      offer(16'hD123);
      chk(na, 1'b1);
      chk(wr, 1'b0);
      chk(cf_o, cf);
   endtask
   initial begin
      #100000;
      num_errors++;
      test_done();
   end
   initial begin
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      chk(cf_o, 1'b0);
      t_all_ops();
      t_edges();
      t_nonarith();
      test_done();
   end
endmodule // nad_arith_decoder_tb
`default_nettype wire
